// ==== fpmc_defs.vh ====
// fpmc_defs.vh: constants of the programmer-mode command interface
// assumes: included by every design file of the block, definitions only
`ifndef FPMC_DEFS_VH
`define FPMC_DEFS_VH

// command codes and page fill byte
`define FPMC_CMD_READ      8'h00
`define FPMC_CMD_PROG      8'h40
`define FPMC_CMD_ERASE     8'h20
`define FPMC_CMD_STAT      8'h71
`define FPMC_FILL_BYTE     8'hff

// page geometry
`define FPMC_PAGE_BYTES    128
`define FPMC_PAGE_LO0      8'h00
`define FPMC_PAGE_LO1      8'h80
`define FPMC_ADDR_W        18

// sequencer states
`define FPMC_ST_READ       3'h0
`define FPMC_ST_WAIT       3'h1
`define FPMC_ST_PGADR      3'h2
`define FPMC_ST_PGDAT      3'h3
`define FPMC_ST_PGRUN      3'h4
`define FPMC_ST_ER2        3'h5
`define FPMC_ST_ERRUN      3'h6
`define FPMC_ST_ST2        3'h7

// status byte bit positions
`define FPMC_SB_ABN        7
`define FPMC_SB_CMD        6
`define FPMC_SB_PRG        5
`define FPMC_SB_ERS        4
`define FPMC_SB_CNT        1
`define FPMC_SB_ADR        0

// operation times in microseconds and clock rate in MHz
`define FPMC_CLK_MHZ       10
`define FPMC_WRITE_US      1000
`define FPMC_ERASE_US      100000

`endif

// ==== fpmc_fifo.v ====
// fpmc_fifo.v: small synchronous fifo for program data bytes
// assumes: one clock, clock enable freezes state, async active-high reset
`timescale 1ns/10ps
`include "fpmc_defs.vh"

module fpmc_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = 8,
   parameter AW    = 3
)(
   // clock and reset
   input  wire             mclk,
   input  wire             sys_rst,
   input  wire             clk_en,
   // fill side
   input  wire             in_valid,
   output wire             in_ready,
   input  wire [WIDTH-1:0] in_data,
   // drain side
   output wire             out_valid,
   input  wire             out_ready,
   output wire [WIDTH-1:0] out_data
);

   reg [WIDTH-1:0] mem_r [0:DEPTH-1];
   reg [AW-1:0]    wr_ptr_r;
   reg [AW-1:0]    rd_ptr_r;
   reg [AW:0]      count_r;
   wire            push;
   wire            pop;

   assign in_ready  = (count_r != DEPTH[AW:0]);
   assign out_valid = (count_r != {(AW+1){1'b0}});
   assign out_data  = mem_r[rd_ptr_r];
   assign push      = clk_en & in_valid & in_ready;
   assign pop       = clk_en & out_valid & out_ready;

   always @(posedge mclk)
   begin
      if (push)
         mem_r[wr_ptr_r] <= in_data;
   end

   always @(posedge mclk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         wr_ptr_r <= {AW{1'b0}};
         rd_ptr_r <= {AW{1'b0}};
         count_r  <= {(AW+1){1'b0}};
      end
      else
      begin
         if (push)
            wr_ptr_r <= (wr_ptr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_r + 1'b1;
         if (pop)
            rd_ptr_r <= (rd_ptr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_r + 1'b1;
         if (push & ~pop)
            count_r <= count_r + 1'b1;
         else if (pop & ~push)
            count_r <= count_r - 1'b1;
      end
   end

endmodule

// ==== fpmc_cmd_if.v ====
// fpmc_cmd_if.v: programmer-mode command interface of the flash array
// assumes: pins from the socket are asynchronous to mclk; the array port
// answers reads combinationally and accepts one page byte per cycle
// Contract
// R1: programmer straps clock pins for crystal with pll x4 and mode pins all ones.
// R2: programmer holds write-permit pin high for program and erase command writes.
// R3: select low: output strobe reads, write strobe writes, else data pins float.
// R4: deselect leaves the device operating, never in standby.
// R5: command 00 enters memory read mode; each read address returns its byte.
// R6: memory read mode serves any number of reads without further commands.
// R7: memory read mode accepts commands as the command wait state does.
// R8: after power-on the device is in memory read mode.
// R9: program, erase and status read return to the command wait state.
// R10: command 40 then 128 data writes programs the whole page together.
// R11: programmer pads unused page bytes with ff.
// R12: page address low byte not 00 or 80 still writes but flags an error.
// R13: page address is taken from the second cycle only.
// R14: programmer issues no command while programming runs.
// R15: programmer programs each page only once.
// R16: command 20 twice erases the whole array, end shown by polling.
// R17: command 71 twice enters status read, showing error detail.
// R18: bit 7 shows operation end, bit 6 shows normal end.
// R19: polling flags are held until the next command write, read on select+strobe.
// R20: polling reads 00 running, 80 abnormal, c0 normal, low bits zero.
// R21: status byte: abnormal, command, program, erase, count, address errors.
// R22: status byte is kept until a command for another mode.
// R23: byte is taken at write strobe rise under select, strobe synchronised.
// R24: command writes are ignored while program or erase is busy.
`timescale 1ns/10ps
`include "fpmc_defs.vh"

module fpmc_cmd_if #(
   parameter WRITE_CYC  = (`FPMC_WRITE_US * `FPMC_CLK_MHZ),
   parameter ERASE_CYC  = (`FPMC_ERASE_US * `FPMC_CLK_MHZ),
   parameter FIFO_DEPTH = 8
)(
   // clock and reset
   mclk,
   sys_rst,
   clk_en,
   // socket pins
   chip_sel_n,
   out_strobe_n,
   write_strobe_n,
   flash_write_permit_pin,
   address_lines,
   data_pins_in,
   data_pins_out,
   data_pins_oe,
   // flash array side
   array_rd_addr,
   array_rd_data,
   array_wr_valid,
   array_wr_ready,
   array_wr_data,
   array_pg_addr,
   array_pg_start,
   array_er_start,
   array_done,
   array_fail,
   // status
   busy,
   mode_state
);
   // clock and reset
   input  wire                     mclk;
   input  wire                     sys_rst;
   input  wire                     clk_en;
   // socket pins
   input  wire                     chip_sel_n;
   input  wire                     out_strobe_n;
   input  wire                     write_strobe_n;
   input  wire                     flash_write_permit_pin;
   input  wire [`FPMC_ADDR_W-1:0]  address_lines;
   input  wire [7:0]               data_pins_in;
   output reg  [7:0]               data_pins_out;
   output reg                      data_pins_oe;
   // flash array side
   output reg  [`FPMC_ADDR_W-1:0]  array_rd_addr;
   input  wire [7:0]               array_rd_data;
   output reg                      array_wr_valid;
   input  wire                     array_wr_ready;
   output reg  [7:0]               array_wr_data;
   output reg  [`FPMC_ADDR_W-1:0]  array_pg_addr;
   output reg                      array_pg_start;
   output reg                      array_er_start;
   input  wire                     array_done;
   input  wire                     array_fail;
   // status
   output reg                      busy;
   output reg  [2:0]               mode_state;

   // pin synchronisers; R4: no standby state exists, deselect only floats pins
   reg [2:0]               strb_s1_r;
   reg [2:0]               strb_s2_r;
   reg                     fwe_s1_r;
   reg                     fwe_s2_r;
   reg [7:0]               dat_s1_r;
   reg [7:0]               dat_s2_r;
   reg [`FPMC_ADDR_W-1:0]  adr_s1_r;
   reg [`FPMC_ADDR_W-1:0]  adr_s2_r;
   reg                     we_d_r;
   reg [7:0]               wbyte_r;
   reg                     wpulse_r;

   always @(posedge mclk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         strb_s1_r <= 3'h7;
         strb_s2_r <= 3'h7;
         fwe_s1_r  <= 1'b0;
         fwe_s2_r  <= 1'b0;
         dat_s1_r  <= 8'h00;
         dat_s2_r  <= 8'h00;
         adr_s1_r  <= {`FPMC_ADDR_W{1'b0}};
         adr_s2_r  <= {`FPMC_ADDR_W{1'b0}};
         we_d_r    <= 1'b0;
         wbyte_r   <= 8'h00;
         wpulse_r  <= 1'b0;
      end
      else if (clk_en)
      begin
         strb_s1_r <= {chip_sel_n, out_strobe_n, write_strobe_n};
         strb_s2_r <= strb_s1_r;
         fwe_s1_r  <= flash_write_permit_pin;
         fwe_s2_r  <= fwe_s1_r;
         dat_s1_r  <= data_pins_in;
         dat_s2_r  <= dat_s1_r;
         adr_s1_r  <= address_lines;
         adr_s2_r  <= adr_s1_r;
         // write accepted while select low and output strobe high
         we_d_r    <= ~strb_s2_r[2] & strb_s2_r[1] & ~strb_s2_r[0];
         wpulse_r  <= 1'b0;
         if (we_d_r & strb_s2_r[0]) // R23
         begin
            wpulse_r <= 1'b1;
            wbyte_r  <= dat_s2_r;
         end
      end
   end

   // sequencer
   reg [2:0]               st_r;
   reg [2:0]               st_nxt;
   reg [7:0]               cnt_r;
   reg [31:0]              tmr_r;
   reg [7:0]               stat_r;
   reg [1:0]               poll_r;
   reg                     poll_en_r;
   reg                     stat_en_r;
   reg                     run_er_r;
   wire                    f_ready;
   wire                    f_valid;
   wire [7:0]              f_data;
   reg                     f_push;
   wire                    wr_load;

   // output stage reloads when empty or when the array takes its byte
   assign wr_load = ~array_wr_valid | array_wr_ready;

   fpmc_fifo #(
      .WIDTH     (8),
      .DEPTH     (FIFO_DEPTH),
      .AW        (3)
   ) u_fifo (
      .mclk      (mclk),
      .sys_rst   (sys_rst),
      .clk_en    (clk_en),
      .in_valid  (f_push),
      .in_ready  (f_ready),
      .in_data   (wbyte_r),
      .out_valid (f_valid),
      .out_ready (wr_load),
      .out_data  (f_data)
   );

   function is_cmd;
      input [7:0] b;
      begin
         is_cmd = (b == `FPMC_CMD_READ) | (b == `FPMC_CMD_PROG) |
                  (b == `FPMC_CMD_ERASE) | (b == `FPMC_CMD_STAT);
      end
   endfunction

   wire cmd_ok_st = (st_r == `FPMC_ST_READ) | (st_r == `FPMC_ST_WAIT);

   always @*
   begin
      st_nxt = st_r;
      f_push = 1'b0;
      if (wpulse_r)
      begin
         case (st_r)
            `FPMC_ST_READ, `FPMC_ST_WAIT: // R7
            begin
               if (wbyte_r == `FPMC_CMD_READ)
                  st_nxt = `FPMC_ST_READ; // R5
               // program and erase are refused without write permit
               else if ((wbyte_r == `FPMC_CMD_PROG) & fwe_s2_r)
                  st_nxt = `FPMC_ST_PGADR; // R10
               else if ((wbyte_r == `FPMC_CMD_ERASE) & fwe_s2_r)
                  st_nxt = `FPMC_ST_ER2; // R16
               else if (wbyte_r == `FPMC_CMD_STAT)
                  st_nxt = `FPMC_ST_ST2; // R17
               else
                  st_nxt = `FPMC_ST_WAIT;
            end
            `FPMC_ST_PGADR:
            begin
               f_push = 1'b1;
               st_nxt = `FPMC_ST_PGDAT;
            end
            `FPMC_ST_PGDAT:
               f_push = 1'b1;
            `FPMC_ST_ER2, `FPMC_ST_ST2:
               st_nxt = `FPMC_ST_WAIT;
            default:
               st_nxt = st_r; // R24
         endcase
      end
      if ((st_r == `FPMC_ST_PGDAT) & (cnt_r == `FPMC_PAGE_BYTES) & ~f_valid & ~array_wr_valid)
         st_nxt = `FPMC_ST_PGRUN;
      if ((st_r == `FPMC_ST_PGRUN) | (st_r == `FPMC_ST_ERRUN))
      begin
         if (array_done | (tmr_r == 32'h0000_0000))
            st_nxt = `FPMC_ST_WAIT; // R9
      end
      if (wpulse_r & (st_r == `FPMC_ST_ER2) & (wbyte_r == `FPMC_CMD_ERASE))
         st_nxt = `FPMC_ST_ERRUN;
   end

   always @(posedge mclk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         st_r      <= `FPMC_ST_READ; // R8
         cnt_r     <= 8'h00;
         tmr_r     <= 32'h0000_0000;
         stat_r    <= 8'h00;
         poll_r    <= 2'b00;
         poll_en_r <= 1'b0;
         stat_en_r <= 1'b0;
         run_er_r  <= 1'b0;
         array_pg_addr  <= {`FPMC_ADDR_W{1'b0}};
         array_pg_start <= 1'b0;
         array_er_start <= 1'b0;
      end
      else if (clk_en)
      begin
         st_r           <= st_nxt;
         array_pg_start <= 1'b0;
         array_er_start <= 1'b0;
         if (wpulse_r & cmd_ok_st)
         begin
            // new command ends polling display; R19
            poll_en_r <= 1'b0;
            poll_r    <= 2'b00;
            if (wbyte_r != `FPMC_CMD_STAT) // R22
            begin
               stat_en_r <= 1'b0;
               stat_r    <= 8'h00;
            end
            if (~is_cmd(wbyte_r))
            begin
               stat_r[`FPMC_SB_CMD] <= 1'b1;
               stat_r[`FPMC_SB_ABN] <= 1'b1;
            end
            if (((wbyte_r == `FPMC_CMD_PROG) | (wbyte_r == `FPMC_CMD_ERASE)) & ~fwe_s2_r)
            begin
               stat_r[`FPMC_SB_CMD] <= 1'b1;
               stat_r[`FPMC_SB_ABN] <= 1'b1;
            end
         end
         if (wpulse_r & (st_r == `FPMC_ST_PGADR))
         begin
            array_pg_addr <= adr_s2_r; // R13
            cnt_r <= 8'h01;
            if ((adr_s2_r[7:0] != `FPMC_PAGE_LO0) & (adr_s2_r[7:0] != `FPMC_PAGE_LO1))
            begin
               stat_r[`FPMC_SB_ADR] <= 1'b1; // R12
               stat_r[`FPMC_SB_ABN] <= 1'b1;
            end
         end
         else if (wpulse_r & (st_r == `FPMC_ST_PGDAT) & (cnt_r != `FPMC_PAGE_BYTES))
            cnt_r <= cnt_r + 8'h01;
         if (wpulse_r & (st_r == `FPMC_ST_ER2) & (wbyte_r != `FPMC_CMD_ERASE))
         begin
            stat_r[`FPMC_SB_CMD] <= 1'b1;
            stat_r[`FPMC_SB_ABN] <= 1'b1;
         end
         if (wpulse_r & (st_r == `FPMC_ST_ST2))
         begin
            if (wbyte_r == `FPMC_CMD_STAT)
               stat_en_r <= 1'b1; // R17
            else
            begin
               stat_r[`FPMC_SB_CMD] <= 1'b1;
               stat_r[`FPMC_SB_ABN] <= 1'b1;
            end
         end
         if ((st_r != `FPMC_ST_PGRUN) & (st_nxt == `FPMC_ST_PGRUN))
         begin
            array_pg_start <= 1'b1; // R10
            tmr_r    <= WRITE_CYC;
            run_er_r <= 1'b0;
            poll_en_r <= 1'b1;
         end
         if ((st_r != `FPMC_ST_ERRUN) & (st_nxt == `FPMC_ST_ERRUN))
         begin
            array_er_start <= 1'b1; // R16
            tmr_r    <= ERASE_CYC;
            run_er_r <= 1'b1;
            poll_en_r <= 1'b1;
         end
         if (((st_r == `FPMC_ST_PGRUN) | (st_r == `FPMC_ST_ERRUN)) & (tmr_r != 32'h0000_0000))
            tmr_r <= tmr_r - 32'h0000_0001;
         if (((st_r == `FPMC_ST_PGRUN) | (st_r == `FPMC_ST_ERRUN)) & (st_nxt == `FPMC_ST_WAIT))
         begin
            // R18 R20
            if (array_done & ~array_fail)
               poll_r <= 2'b11;
            else
            begin
               poll_r <= 2'b10;
               stat_r[`FPMC_SB_ABN] <= 1'b1; // R21
               if (run_er_r)
                  stat_r[`FPMC_SB_ERS] <= 1'b1;
               else
                  stat_r[`FPMC_SB_PRG] <= 1'b1;
               if (~array_done)
                  stat_r[`FPMC_SB_CNT] <= 1'b1;
            end
         end
      end
   end

   // registered outputs
   always @(posedge mclk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         data_pins_out  <= 8'h00;
         data_pins_oe   <= 1'b0;
         array_rd_addr  <= {`FPMC_ADDR_W{1'b0}};
         array_wr_valid <= 1'b0;
         array_wr_data  <= 8'h00;
         busy           <= 1'b0;
         mode_state     <= `FPMC_ST_READ;
      end
      else if (clk_en)
      begin
         array_rd_addr  <= adr_s2_r; // R6
         if (wr_load)
         begin
            array_wr_valid <= f_valid;
            array_wr_data  <= f_data;
         end
         busy           <= (st_r == `FPMC_ST_PGRUN) | (st_r == `FPMC_ST_ERRUN);
         mode_state     <= st_r;
         // R3: drive only with select and output strobe low, write strobe high
         data_pins_oe   <= ~strb_s2_r[2] & ~strb_s2_r[1] & strb_s2_r[0];
         if (stat_en_r)
            data_pins_out <= stat_r; // R21
         else if (poll_en_r)
            data_pins_out <= {poll_r, 6'h00}; // R19 R20
         else if (st_r == `FPMC_ST_READ)
            data_pins_out <= array_rd_data; // R5
         else
            data_pins_out <= 8'h00;
      end
   end

endmodule

// ==== fpmc_cmd_if_assertions.sv ====
// fpmc_cmd_if_assertions.sv: port checker of the programmer-mode command interface
// assumes: bound to fpmc_cmd_if, single clock, clk_en held high
`timescale 1ns/10ps
`include "fpmc_defs.vh"
module fpmc_cmd_if_chk (
   // clock and reset
   input wire logic        mclk,
   input wire logic        sys_rst,
   // socket pins
   input wire logic        chip_sel_n,
   input wire logic        out_strobe_n,
   input wire logic        write_strobe_n,
   input wire logic [17:0] address_lines,
   input wire logic [7:0]  data_pins_out,
   input wire logic        data_pins_oe,
   // array side and status
   input wire logic [17:0] array_rd_addr,
   input wire logic        array_pg_start,
   input wire logic        array_er_start,
   input wire logic        array_done,
   input wire logic        busy,
   input wire logic [2:0]  mode_state
);
   default clocking @(posedge mclk); endclocking
   default disable iff (sys_rst);
   sequence s_read_sel;
      (!chip_sel_n && !out_strobe_n && write_strobe_n) [*4];
   endsequence
   sequence s_run;
      busy [*3];
   endsequence
   a_read_drive: assert property (s_read_sel |-> data_pins_oe)
      else $error("data pins not driven in read");
   a_desel_float: assert property (chip_sel_n [*4] |-> !data_pins_oe)
      else $error("data pins driven while deselected");
   a_rd_addr_follow: assert property ($stable(address_lines) [*5] |-> array_rd_addr == address_lines)
      else $error("read address not passed to array");
   a_pg_start_busy: assert property (array_pg_start |=> busy)
      else $error("program start without busy");
   a_er_start_busy: assert property (array_er_start |=> busy)
      else $error("erase start without busy");
   a_done_to_wait: assert property (busy && array_done |-> ##[1:3] (!busy && mode_state == `FPMC_ST_WAIT))
      else $error("no return to command wait after done");
   a_busy_run_state: assert property (s_run |-> mode_state == `FPMC_ST_PGRUN || mode_state == `FPMC_ST_ERRUN)
      else $error("busy outside a run state");
   a_busy_ignore: assert property (busy ##1 busy |-> $stable(mode_state))
      else $error("state moved while busy");
   a_busy_poll: assert property (s_run ##0 (data_pins_oe && !array_done) |-> data_pins_out == 8'h00)
      else $error("poll byte not zero while running");
endmodule

// ==== fpmc_prog_model.sv ====
// fpmc_prog_model.sv: external programmer driving the socket pins
// assumes: tasks are called from the bench; permit may be changed by the bench
`timescale 1ns/10ps
module fpmc_prog_model (
   // clock
   input wire logic        mclk,
   // socket pins toward the device
   output logic            cs_n,
   output logic            oe_n,
   output logic            we_n,
   output logic            permit,
   output logic [17:0]     addr,
   output logic [7:0]      din,
   // device drive
   input wire logic [7:0]  dout,
   input wire logic        doe
);
   logic       drv_r;
   logic [7:0] dat_r;
   logic [7:0] last_r;
   initial
   begin
      cs_n = 1'b1;
      oe_n = 1'b1;
      we_n = 1'b1;
      permit = 1'b1;
      addr = 18'h0;
      drv_r = 1'b0;
      dat_r = 8'h00;
      last_r = 8'h00;
   end
   // floating bus shows a toggling level, never a stale byte
   assign din = drv_r ? dat_r : (doe ? dout : ~last_r);
   always @(posedge mclk)
      last_r <= din;
   task automatic wr(input logic [17:0] a, input logic [7:0] d);
      @(posedge mclk);
      cs_n <= 1'b0;
      addr <= a;
      dat_r <= d;
      drv_r <= 1'b1;
      we_n <= 1'b0;
      repeat (4) @(posedge mclk);
      we_n <= 1'b1;
      repeat (5) @(posedge mclk);
      cs_n <= 1'b1;
      drv_r <= 1'b0;
      repeat (8) @(posedge mclk);
   endtask
   task automatic rd(input logic [17:0] a, output logic [7:0] v);
      @(posedge mclk);
      cs_n <= 1'b0;
      oe_n <= 1'b0;
      addr <= a;
      repeat (8) @(posedge mclk);
      @(negedge mclk);
      v = din;
      @(posedge mclk);
      cs_n <= 1'b1;
      oe_n <= 1'b1;
      repeat (8) @(posedge mclk);
   endtask
endmodule

// ==== fpmc_cmd_if_test.sv ====
// fpmc_cmd_if_test.sv: self-checking bench of the command interface
// assumes: flash array emulated here, programmer in fpmc_prog_model
`timescale 1ns/10ps
`include "fpmc_defs.vh"
module fpmc_cmd_if_test;
   logic        mclk, sys_rst, clk_en;
   logic        cs_n, oe_n, we_n, permit, doe;
   logic [17:0] addr, array_rd_addr, array_pg_addr;
   logic [7:0]  din, dout, array_wr_data, nb_r, cnt_r, run_cyc;
   logic        array_wr_valid, array_pg_start, array_er_start, busy;
   logic        wr_rdy, done_r, fl_r, mute;
   logic [2:0]  mode_state;
   logic [7:0]  pg_buf [0:127];
   int          error_cnt, compares;
   function automatic logic [7:0] arr_val(input logic [17:0] a);
      return a[7:0] ^ a[15:8] ^ 8'h3c;
   endfunction
   fpmc_cmd_if #(.WRITE_CYC(100), .ERASE_CYC(100), .FIFO_DEPTH(8)) u_fpmc_cmd_if (
      .mclk(mclk), .sys_rst(sys_rst), .clk_en(clk_en), .chip_sel_n(cs_n), .out_strobe_n(oe_n),
      .write_strobe_n(we_n), .flash_write_permit_pin(permit), .address_lines(addr),
      .data_pins_in(din), .data_pins_out(dout), .data_pins_oe(doe), .array_rd_addr(array_rd_addr),
      .array_rd_data(arr_val(array_rd_addr)), .array_wr_valid(array_wr_valid), .array_wr_ready(wr_rdy),
      .array_wr_data(array_wr_data), .array_pg_addr(array_pg_addr), .array_pg_start(array_pg_start),
      .array_er_start(array_er_start), .array_done(done_r), .array_fail(fl_r), .busy(busy),
      .mode_state(mode_state));
   fpmc_prog_model u_fpmc_prog_model (.mclk(mclk), .cs_n(cs_n), .oe_n(oe_n), .we_n(we_n),
      .permit(permit), .addr(addr), .din(din), .dout(dout), .doe(doe));
   initial
   begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end
   // array: takes page bytes, ends a run after run_cyc unless muted
   always @(posedge mclk)
   begin
      done_r <= 1'b0;
      if (array_wr_valid && wr_rdy)
      begin
         pg_buf[nb_r[6:0]] <= array_wr_data;
         nb_r <= nb_r + 8'h01;
      end
      if (array_pg_start || array_er_start)
         cnt_r <= run_cyc;
      else if (cnt_r != 8'h00)
      begin
         cnt_r <= cnt_r - 8'h01;
         done_r <= (cnt_r == 8'h01) && !mute;
      end
   end
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic w(input logic [17:0] a, input logic [7:0] d);
      u_fpmc_prog_model.wr(a, d);
   endtask
   task automatic rp(input logic [17:0] a, input logic [7:0] m, input logic [7:0] e);
      logic [7:0] v;
      u_fpmc_prog_model.rd(a, v);
      chk8(v & m, e);
   endtask
   task automatic st(input logic [7:0] m, input logic [7:0] e);
      w(18'h0, `FPMC_CMD_STAT);
      w(18'h0, `FPMC_CMD_STAT);
      rp(18'h0, m, e);
   endtask
   task automatic wait_idle;
      int n;
      n = 0;
      @(negedge mclk);
      while (busy !== 1'b0 && n < 300)
      begin
         @(negedge mclk);
         n++;
      end
      chk8({7'h0, busy}, 8'h00);
   endtask
   task automatic t_boot;
      chk8({5'h0, mode_state}, 8'h00);
      for (int i = 0; i < 3; i++)
         rp(18'h1234 + i * 77, 8'hff, arr_val(18'h1234 + i * 77));
      repeat (4) @(negedge mclk);
      chk8({7'h0, doe}, 8'h00);
      rp(18'h3ff01, 8'hff, arr_val(18'h3ff01));
      $display("t_boot done");
   endtask
   task automatic t_prog(input logic [17:0] pa, input logic fl, input logic [7:0] pm, pe, sm, se);
      nb_r = 8'h00;
      fl_r = fl;
      run_cyc = 8'd8;
      wr_rdy <= 1'b0;
      w(18'h0, `FPMC_CMD_PROG);
      for (int i = 0; i < 128; i++)
      begin
         if (i == 3)
            wr_rdy <= 1'b1;
         w(pa, (i < 16) ? 8'ha5 ^ i[7:0] : `FPMC_FILL_BYTE);
      end
      wait_idle;
      chk8({5'h0, mode_state}, {5'h0, `FPMC_ST_WAIT});
      rp(pa, pm, pe);
      rp(pa, pm, pe);
      chk8(nb_r, 8'h80);
      chk8(pg_buf[0], 8'ha5);
      chk8(pg_buf[127], `FPMC_FILL_BYTE);
      chk8(array_pg_addr[7:0], pa[7:0]);
      st(sm, se);
      $display("t_prog %h done", pa);
   endtask
   task automatic t_erase(input logic fl, mu, input logic [7:0] rn, pe, sm, se);
      fl_r = fl;
      mute = mu;
      run_cyc = rn;
      w(18'h0, `FPMC_CMD_ERASE);
      w(18'h0, `FPMC_CMD_ERASE);
      if (rn > 8'd20)
      begin
         w(18'h0, `FPMC_CMD_READ);
         chk8({5'h0, mode_state}, {5'h0, `FPMC_ST_ERRUN});
         rp(18'h0, 8'hff, 8'h00);
      end
      wait_idle;
      mute = 1'b0;
      chk8({5'h0, mode_state}, {5'h0, `FPMC_ST_WAIT});
      rp(18'h0, 8'hff, pe);
      rp(18'h0, 8'hff, pe);
      st(sm, se);
      $display("t_erase %h done", se);
   endtask
   task automatic t_keep;
      st(8'h90, 8'h90);
      w(18'h0, `FPMC_CMD_READ);
      rp(18'h00a5c, 8'hff, arr_val(18'h00a5c));
      st(8'hf3, 8'h00);
      $display("t_keep done");
   endtask
   task automatic t_cmd_err;
      logic [7:0] cmd [3] = '{8'h55, `FPMC_CMD_PROG, `FPMC_CMD_ERASE};
      for (int i = 0; i < 3; i++)
      begin
         u_fpmc_prog_model.permit <= (i == 0);
         w(18'h0, cmd[i]);
         if (i == 2)
            w(18'h0, cmd[i]);
         st(8'hc0, 8'hc0);
      end
      u_fpmc_prog_model.permit <= 1'b1;
      $display("t_cmd_err done");
   endtask
   task automatic give_verdict;
      $display("compares %0d error_cnt %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial
   begin
      repeat (40000) @(posedge mclk);
      error_cnt++;
      give_verdict;
   end
   initial
   begin
      sys_rst = 1'b1;
      clk_en = 1'b1;
      wr_rdy = 1'b1;
      nb_r = 8'h00;
      cnt_r = 8'h00;
      run_cyc = 8'd8;
      fl_r = 1'b0;
      mute = 1'b0;
      repeat (4) @(posedge mclk);
      sys_rst <= 1'b0;
      repeat (2) @(posedge mclk);
      t_boot;
      t_prog(18'h01280, 1'b0, 8'hff, 8'hc0, 8'hf3, 8'h00);
      t_prog(18'h02340, 1'b0, 8'h80, 8'h80, 8'h01, 8'h01);
      t_prog(18'h03300, 1'b1, 8'hff, 8'h80, 8'ha0, 8'ha0);
      t_erase(1'b0, 1'b0, 8'd60, 8'hc0, 8'hf3, 8'h00);
      t_erase(1'b0, 1'b1, 8'd4, 8'h80, 8'h82, 8'h82);
      t_erase(1'b1, 1'b0, 8'd4, 8'h80, 8'h90, 8'h90);
      t_keep;
      t_cmd_err;
      give_verdict;
   end
endmodule
bind fpmc_cmd_if fpmc_cmd_if_chk u_fpmc_cmd_if_chk (.mclk(mclk), .sys_rst(sys_rst), .chip_sel_n(chip_sel_n),
   .out_strobe_n(out_strobe_n), .write_strobe_n(write_strobe_n), .address_lines(address_lines),
   .data_pins_out(data_pins_out), .data_pins_oe(data_pins_oe), .array_rd_addr(array_rd_addr),
   .array_pg_start(array_pg_start), .array_er_start(array_er_start), .array_done(array_done),
   .busy(busy), .mode_state(mode_state));
